// ---- pkg/ebct_regs.svh ----
// Timing counts of the external bus cycle sequencer
`ifndef EBCT_REGS_SVH
`define EBCT_REGS_SVH
// One input clock period is one i_clock cycle (20 ns at 50 MHz)
`define EBCT_TCP_NS          20
`define EBCT_CLK_NS          20
`define EBCT_TCP_CYC         ((`EBCT_TCP_NS + `EBCT_CLK_NS - 1) / `EBCT_CLK_NS)
// Machine cycle of 12 periods: six states of two phases
`define EBCT_CYCLE_LEN       12
`define EBCT_ADDR_SETUP      (1 * `EBCT_TCP_CYC)
`define EBCT_ALE_WIDTH       (2 * `EBCT_TCP_CYC)
`define EBCT_ALE_TO_PROG     (1 * `EBCT_TCP_CYC)
`define EBCT_PROG_WIDTH      (3 * `EBCT_TCP_CYC)
`define EBCT_ALE_TO_STROBE   (3 * `EBCT_TCP_CYC)
`define EBCT_STROBE_WIDTH    (6 * `EBCT_TCP_CYC)
// Phase index within the machine cycle (0 = state one phase one .. 11 = state six phase two)
`define EBCT_STATE5_PHASE2   9
`define EBCT_STATE6_PHASE2   11
`endif

// ---- pkg/ebct_pkg.sv ----
// Types of the external bus cycle sequencer
package ebct_pkg;
   typedef enum logic [1:0] {
      EBCT_OP_FETCH = 2'b00,
      EBCT_OP_READ  = 2'b01,
      EBCT_OP_WRITE = 2'b10
   } ebct_op_t;

   typedef struct packed {
      ebct_op_t    op;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } ebct_req_t;

   typedef enum logic [2:0] {
      EBCT_ST_IDLE   = 3'b000,
      EBCT_ST_SETUP  = 3'b001,
      EBCT_ST_ALE    = 3'b010,
      EBCT_ST_HOLD   = 3'b011,
      EBCT_ST_STROBE = 3'b100,
      EBCT_ST_TAIL   = 3'b101
   } ebct_state_t;
endpackage : ebct_pkg

// ---- src/ebct_bus_seq.sv ----
// External multiplexed bus cycle sequencer with port sample and update timing
`timescale 1ns/1ps
`include "ebct_regs.svh"

module ebct_bus_seq
   import ebct_pkg::*;
#(
   parameter int PORT_W = 8
) (
   input  wire logic              i_clock,
   input  wire logic              i_reset,
   input  wire logic              i_req_valid,
   input  wire ebct_req_t         i_req,
   output logic                   o_req_ready,
   output logic                   o_rsp_valid,
   output logic [7:0]             o_rsp_data,
   input  wire logic [7:0]        i_low_addr_data_port,
   output logic [7:0]             o_low_addr_data_port,
   output logic                   o_low_addr_data_port_oe,
   output logic [7:0]             o_high_addr_port,
   output logic                   o_addr_latch_strobe,
   output logic                   o_prog_store_strobe_n,
   output logic                   o_read_strobe_n,
   output logic                   o_write_strobe_n,
   input  wire logic [PORT_W-1:0] i_port_out_value,
   input  wire logic              i_port_out_write,
   input  wire logic [PORT_W-1:0] i_port_pins,
   output logic [PORT_W-1:0]      o_port_pins,
   output logic [PORT_W-1:0]      o_port_sample,
   output logic                   o_state5_phase2,
   output logic                   o_state6_phase2
);

   localparam logic [3:0] CYCLE_LAST    = 4'(`EBCT_CYCLE_LEN - 1);
   localparam logic [3:0] STATE5_PHASE2 = 4'(`EBCT_STATE5_PHASE2);
   localparam logic [3:0] STATE6_PHASE2 = 4'(`EBCT_STATE6_PHASE2);
   localparam logic [3:0] SETUP_LEN     = 4'(`EBCT_ADDR_SETUP);
   localparam logic [3:0] ALE_LEN       = 4'(`EBCT_ALE_WIDTH);
   localparam logic [3:0] PROG_GAP      = 4'(`EBCT_ALE_TO_PROG);
   localparam logic [3:0] PROG_LEN      = 4'(`EBCT_PROG_WIDTH);
   localparam logic [3:0] RW_GAP        = 4'(`EBCT_ALE_TO_STROBE);
   localparam logic [3:0] RW_LEN        = 4'(`EBCT_STROBE_WIDTH);

   // ************************************************************
   // Machine cycle phase counter
   // ************************************************************
   logic [3:0] phase;

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         phase <= 4'h0;
      end else if (phase == CYCLE_LAST) begin
         phase <= 4'h0;
      end else begin
         phase <= phase + 4'h1;
      end
   end

   assign o_state5_phase2 = (phase == STATE5_PHASE2);
   assign o_state6_phase2 = (phase == STATE6_PHASE2);

   // ************************************************************
   // Port pins: three-stage input, sample and update
   // ************************************************************
   logic [PORT_W-1:0] pin_s1;
   logic [PORT_W-1:0] pin_s2;
   logic [PORT_W-1:0] pin_s3;
   logic [PORT_W-1:0] pin_stable;
   logic [PORT_W-1:0] port_pending;

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         pin_s1     <= '0;
         pin_s2     <= '0;
         pin_s3     <= '0;
         pin_stable <= '0;
      end else begin
         pin_s1 <= i_port_pins;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         // A bit changes only once the second and third stages agree
         pin_stable <= (pin_stable & (pin_s2 ^ pin_s3)) | (pin_s2 & ~(pin_s2 ^ pin_s3));
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_port_sample <= '0;
      end else if (phase == STATE5_PHASE2) begin
         o_port_sample <= pin_stable;
      end
   end

   // Pins default high like a quasi-bidirectional port after reset
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         port_pending <= '1;
         o_port_pins  <= '1;
      end else begin
         if (i_port_out_write) begin
            port_pending <= i_port_out_value;
         end
         if (phase == STATE6_PHASE2) begin
            o_port_pins <= port_pending;
         end
      end
   end

   // ************************************************************
   // Bus cycle sequencer
   // ************************************************************
   ebct_state_t state;
   ebct_req_t   cur;
   logic [3:0]  cnt;

   assign o_req_ready = (state == EBCT_ST_IDLE);

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         state <= EBCT_ST_IDLE;
         cnt   <= 4'h0;
         cur   <= '0;
      end else begin
         case (state)
            EBCT_ST_IDLE: begin
               if (i_req_valid) begin
                  cur   <= i_req;
                  cnt   <= SETUP_LEN - 4'h1;
                  state <= EBCT_ST_SETUP;
               end
            end
            EBCT_ST_SETUP: begin
               if (cnt == 4'h0) begin
                  cnt   <= ALE_LEN - 4'h1;
                  state <= EBCT_ST_ALE;
               end else begin
                  cnt <= cnt - 4'h1;
               end
            end
            EBCT_ST_ALE: begin
               if (cnt == 4'h0) begin
                  cnt   <= ((cur.op == EBCT_OP_FETCH) ? PROG_GAP : RW_GAP) - 4'h1;
                  state <= EBCT_ST_HOLD;
               end else begin
                  cnt <= cnt - 4'h1;
               end
            end
            EBCT_ST_HOLD: begin
               if (cnt == 4'h0) begin
                  cnt   <= ((cur.op == EBCT_OP_FETCH) ? PROG_LEN : RW_LEN) - 4'h1;
                  state <= EBCT_ST_STROBE;
               end else begin
                  cnt <= cnt - 4'h1;
               end
            end
            EBCT_ST_STROBE: begin
               if (cnt == 4'h0) begin
                  state <= EBCT_ST_TAIL;
               end else begin
                  cnt <= cnt - 4'h1;
               end
            end
            default: begin
               // One period after the strobe rises: write data hold, bus float
               state <= EBCT_ST_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Pin drivers, all registered
   // ************************************************************
   logic is_fetch;
   logic is_write;
   assign is_fetch = (cur.op == EBCT_OP_FETCH);
   assign is_write = (cur.op == EBCT_OP_WRITE);

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_addr_latch_strobe     <= 1'b0;
         o_prog_store_strobe_n   <= 1'b1;
         o_read_strobe_n         <= 1'b1;
         o_write_strobe_n        <= 1'b1;
         o_low_addr_data_port    <= 8'h00;
         o_low_addr_data_port_oe <= 1'b0;
         o_high_addr_port        <= 8'h00;
      end else begin
         o_addr_latch_strobe   <= 1'b0;
         o_prog_store_strobe_n <= 1'b1;
         o_read_strobe_n       <= 1'b1;
         o_write_strobe_n      <= 1'b1;
         case (state)
            EBCT_ST_IDLE: begin
               o_low_addr_data_port_oe <= 1'b0;
               if (i_req_valid) begin
                  // Address out one period ahead of the latch strobe
                  o_low_addr_data_port    <= i_req.addr[7:0];
                  o_high_addr_port        <= i_req.addr[15:8];
                  o_low_addr_data_port_oe <= 1'b1;
               end
            end
            EBCT_ST_SETUP: begin
               o_addr_latch_strobe <= (cnt == 4'h0);
            end
            EBCT_ST_ALE: begin
               o_addr_latch_strobe <= (cnt != 4'h0);
            end
            EBCT_ST_HOLD: begin
               if (cnt == 4'h0) begin
                  o_prog_store_strobe_n <= ~is_fetch;
                  o_read_strobe_n <= ~(cur.op == EBCT_OP_READ);
                  o_write_strobe_n <= ~is_write;
                  if (is_fetch) begin
                     // Fetch: address held one period past latch fall, then free the bus
                     o_low_addr_data_port_oe <= 1'b0;
                  end
               end else if (cnt == RW_GAP - 4'h2) begin
                  // Address held two periods past latch fall, then turn bus
                  o_low_addr_data_port    <= cur.wdata;
                  o_low_addr_data_port_oe <= is_write;
               end
            end
            EBCT_ST_STROBE: begin
               o_prog_store_strobe_n <= ~is_fetch | (cnt == 4'h0);
               o_read_strobe_n  <= ~(cur.op == EBCT_OP_READ) | (cnt == 4'h0);
               o_write_strobe_n <= ~is_write | (cnt == 4'h0);
            end
            default: begin
               o_low_addr_data_port_oe <= 1'b0;
            end
         endcase
      end
   end

   // ************************************************************
   // Read data capture before the strobe rises
   // ************************************************************
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_rsp_valid <= 1'b0;
         o_rsp_data  <= 8'h00;
      end else begin
         o_rsp_valid <= 1'b0;
         // Last low cycle of the strobe: memory had 3 or 6 periods of access
         if (state == EBCT_ST_STROBE && cnt == 4'h0 && !is_write) begin
            o_rsp_data  <= i_low_addr_data_port;
            o_rsp_valid <= 1'b1;
         end
      end
   end

endmodule : ebct_bus_seq

// ---- verification/ebct_bus_seq_asserts.sv ----
// Checker of strobe sequencing and port timing of the bus sequencer
`timescale 1ns/1ps
module ebct_bus_seq_asserts #(
   parameter int PORT_W = 8
) (
   input  wire logic              i_clock,
   input  wire logic              i_reset,
   input  wire logic [7:0]        o_low_addr_data_port,
   input  wire logic              o_low_addr_data_port_oe,
   input  wire logic [7:0]        o_high_addr_port,
   input  wire logic              o_addr_latch_strobe,
   input  wire logic              o_prog_store_strobe_n,
   input  wire logic              o_read_strobe_n,
   input  wire logic              o_write_strobe_n,
   input  wire logic [PORT_W-1:0] o_port_pins,
   input  wire logic              o_state5_phase2,
   input  wire logic              o_state6_phase2
);
   wire       ale = o_addr_latch_strobe;
   wire       psn = o_prog_store_strobe_n;
   wire       stb = o_read_strobe_n && o_write_strobe_n;
   wire       oe  = o_low_addr_data_port_oe;
   wire [7:0] ad  = o_low_addr_data_port;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);
   chk_ale_width: assert property ($rose(ale) |-> ale [*2] ##1 !ale)
      else $error("latch strobe width wrong");
   chk_prog_gap: assert property ($fell(psn) |-> !$past(ale) && $past(ale, 2))
      else $error("program strobe start wrong");
   chk_prog_width: assert property ($fell(psn) |-> !psn [*3] ##1 psn)
      else $error("program strobe width wrong");
   chk_strobe_gap: assert property ($fell(stb) |-> !$past(ale, 3) && $past(ale, 4))
      else $error("data strobe start wrong");
   chk_strobe_width: assert property ($fell(stb) |-> !stb [*6] ##1 stb)
      else $error("data strobe width wrong");
   chk_addr_setup: assert property ($fell(ale) |-> $past(oe, 2) && $past(ad) == $past(ad, 2))
      else $error("address not set up");
   chk_addr_hold: assert property ($fell(ale) |-> oe && $stable(ad))
      else $error("address not held");
   chk_fetch_float: assert property ($fell(psn) |-> !oe)
      else $error("bus still driven in fetch");
   chk_wdata_setup: assert property ($fell(o_write_strobe_n) |-> $past(oe) && $stable(ad))
      else $error("write data not set up");
   chk_wdata_hold: assert property ($rose(o_write_strobe_n) |-> oe && $stable(ad))
      else $error("write data not held");
   chk_high_stable: assert property (!psn |-> $stable(o_high_addr_port))
      else $error("high address moved in fetch");
   chk_phase_order: assert property (o_state5_phase2 |-> ##2 o_state6_phase2 ##10 o_state5_phase2)
      else $error("phase markers out of order");
   chk_pins_update: assert property ($changed(o_port_pins) |-> $past(o_state6_phase2))
      else $error("port output changed off phase");
   cov_fetch: cover property ($fell(psn));
   cov_read: cover property ($fell(o_read_strobe_n));
   cov_write: cover property ($fell(o_write_strobe_n));
endmodule : ebct_bus_seq_asserts

bind ebct_bus_seq ebct_bus_seq_asserts #(.PORT_W(PORT_W)) i_ebct_bus_seq_asserts (
   .i_clock, .i_reset, .o_low_addr_data_port, .o_low_addr_data_port_oe, .o_high_addr_port,
   .o_addr_latch_strobe, .o_prog_store_strobe_n, .o_read_strobe_n, .o_write_strobe_n,
   .o_port_pins, .o_state5_phase2, .o_state6_phase2);

// ---- verification/ebct_mem_model.sv ----
// Behavioural external program memory, data memory and address latch
`timescale 1ns/1ps
module ebct_mem_model (
   input  wire logic       i_clock,
   input  wire logic       i_slow,
   input  wire logic       i_ale,
   input  wire logic       i_prog_n,
   input  wire logic       i_rd_n,
   input  wire logic       i_wr_n,
   input  wire logic [7:0] i_bus,
   input  wire logic [7:0] i_high,
   output logic [7:0]      o_data,
   output logic            o_oe
);
   logic [7:0] lat;
   logic [7:0] val;
   logic [7:0] dmem [0:255];
   int         age = 0;
   always @(negedge i_ale) lat <= i_bus;
   always @(posedge i_wr_n) dmem[lat] <= i_bus;
   always @(posedge i_clock) age <= (i_prog_n && i_rd_n) ? 0 : age + 1;
   assign val = !i_prog_n ? (lat ^ i_high ^ 8'h5a) : dmem[lat];
   // Slow mode shows wrong data until the last strobe-low cycle in fetch, the last two in read
   assign o_data = (!i_slow || age >= (!i_prog_n ? 2 : 4)) ? val : ~val;
   assign o_oe = !i_prog_n || !i_rd_n;
endmodule : ebct_mem_model

// ---- verification/tb_ebct_bus_seq.sv ----
// Self-checking bench of the external bus cycle sequencer
`timescale 1ns/1ps
module tb_ebct_bus_seq
   import ebct_pkg::*;
;
   logic       clk = 1'b0, rst = 1'b1, vld = 1'b0, pwr = 1'b0, slow = 1'b0;
   ebct_req_t  req = '0;
   logic [7:0] pout = 8'h00, pin = 8'h00, flt = 8'h5a;
   logic [7:0] d_out, m_out, hi, rdata, pins, samp;
   logic       d_oe, m_oe, ale, psn, rdn, wrn, ready, rvalid, s5, s6;
   wire  [7:0] bus = d_oe ? d_out : (m_oe ? m_out : flt);
   int         error_cnt = 0, total_checks = 0;
   always #10 clk = ~clk;
   // Floating bus shows a value that flips every cycle
   always @(negedge clk) flt <= ~flt;
   ebct_bus_seq i_ebct_bus_seq (.i_clock(clk), .i_reset(rst), .i_req_valid(vld), .i_req(req),
      .o_req_ready(ready), .o_rsp_valid(rvalid), .o_rsp_data(rdata),
      .i_low_addr_data_port(bus), .o_low_addr_data_port(d_out),
      .o_low_addr_data_port_oe(d_oe), .o_high_addr_port(hi), .o_addr_latch_strobe(ale),
      .o_prog_store_strobe_n(psn), .o_read_strobe_n(rdn), .o_write_strobe_n(wrn),
      .i_port_out_value(pout), .i_port_out_write(pwr), .i_port_pins(pin),
      .o_port_pins(pins), .o_port_sample(samp), .o_state5_phase2(s5),
      .o_state6_phase2(s6));
   ebct_mem_model i_ebct_mem_model (.i_clock(clk), .i_slow(slow), .i_ale(ale),
      .i_prog_n(psn), .i_rd_n(rdn), .i_wr_n(wrn), .i_bus(bus), .i_high(hi),
      .o_data(m_out), .o_oe(m_oe));
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk8
   // Bounded wait at falling edges for a level
   task automatic wait_hi(input int sel);
      int n;
      for (n = 0; n < 40 && (sel == 0 ? ready : sel == 1 ? rvalid : sel == 5 ? s5 : s6) !== 1'b1; n++)
         @(negedge clk);
      if (n == 40) begin
         error_cnt++;
         report_and_stop();
      end
   endtask : wait_hi
   task automatic issue(input ebct_op_t op, input logic [15:0] a, input logic [7:0] w);
      vld <= 1'b1;
      req <= '{op, a, w};
      wait_hi(0);
      @(negedge clk);
      vld <= 1'b0;
      // Let one edge pass with the request low before the next call
      @(negedge clk);
   endtask : issue
   task automatic t_fetch();
      issue(EBCT_OP_FETCH, 16'h12c4, 8'h00);
      wait_hi(1);
      chk8(rdata, 8'h8c);
      slow <= 1'b1;
      issue(EBCT_OP_FETCH, 16'hff00, 8'h00);
      wait_hi(1);
      chk8(rdata, 8'ha5);
      slow <= 1'b0;
      $display("test fetch done");
   endtask : t_fetch
   task automatic t_data();
      issue(EBCT_OP_WRITE, 16'h0037, 8'hc3);
      issue(EBCT_OP_WRITE, 16'h0038, 8'h96);
      slow <= 1'b1;
      issue(EBCT_OP_READ, 16'h0037, 8'h00);
      wait_hi(1);
      chk8(rdata, 8'hc3);
      slow <= 1'b0;
      issue(EBCT_OP_READ, 16'h0038, 8'h00);
      wait_hi(1);
      chk8(rdata, 8'h96);
      $display("test data done");
   endtask : t_data
   task automatic t_ports();
      pout <= 8'ha5;
      pwr <= 1'b1;
      @(negedge clk);
      pwr <= 1'b0;
      wait_hi(6);
      @(negedge clk);
      chk8(pins, 8'ha5);
      pin <= 8'h3c;
      repeat (5) @(negedge clk);
      wait_hi(5);
      @(negedge clk);
      chk8(samp, 8'h3c);
      pin <= 8'hc3;
      repeat (5) @(negedge clk);
      wait_hi(5);
      @(negedge clk);
      chk8(samp, 8'hc3);
      $display("test ports done");
   endtask : t_ports
   initial begin
      repeat (2) @(negedge clk);
      rst <= 1'b0;
      @(negedge clk);
      t_fetch();
      t_data();
      t_ports();
      report_and_stop();
   end
endmodule : tb_ebct_bus_seq
